//--- design/dgp_pkg.sv
// Package for the dual general-purpose port block: register indices,
// reset values, field positions and the pin-drive carrier types.
// Assumes an APB master with 32-bit data and word-aligned addresses.
package dgp_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_PA_DATA = 10'h005;
  localparam logic [9:0] IDX_PA_DIR  = 10'h085;
  localparam logic [9:0] IDX_AN_CFG  = 10'h09f;
  localparam logic [9:0] IDX_PB_DATA = 10'h006;
  localparam logic [9:0] IDX_PB_DIR  = 10'h086;
  localparam logic [9:0] IDX_OPTION  = 10'h081;
  localparam logic [9:0] IDX_INT_CTL = 10'h0a0;
  localparam logic [9:0] IDX_PERIPH  = 10'h0a1;

  localparam int PA_W = 6;
  localparam int PB_W = 8;

  // Reset values
  localparam logic [5:0] RST_PA_DIR  = 6'h3f;
  localparam logic [7:0] RST_PB_DIR  = 8'hff;
  localparam logic [7:0] RST_OPTION  = 8'hff;
  localparam logic [2:0] RST_AN_CFG  = 3'h0;
  localparam logic [5:0] RST_PA_LAT  = 6'h00;
  localparam logic [7:0] RST_PB_LAT  = 8'h00;

  // Field positions
  localparam int POS_TMR_PIN      = 4;
  localparam int POS_EXT_IRQ_PIN  = 0;
  localparam int POS_PULLUP_DIS_N = 7;
  localparam int POS_CHANGE_FLAG  = 0;
  localparam int POS_WAKE_EN      = 1;
  localparam int POS_PER_TMR      = 0;
  localparam int POS_PER_EXT      = 1;

  // Pin drive of one port
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
  } dgp_pa_drv_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } dgp_pb_drv_s;

  // Per-pin analog selection from the 3-bit configuration field
  function automatic logic [5:0] dgp_analog_mask(input logic [2:0] cfg);
    case (cfg)
      3'h0:    dgp_analog_mask = 6'h2f;
      3'h1:    dgp_analog_mask = 6'h0f;
      3'h2:    dgp_analog_mask = 6'h07;
      3'h3:    dgp_analog_mask = 6'h03;
      3'h4:    dgp_analog_mask = 6'h01;
      default: dgp_analog_mask = 6'h00;
    endcase
  endfunction : dgp_analog_mask

endpackage : dgp_pkg

//--- design/dgp_port.sv
// Two general-purpose ports behind an APB slave: a 6-bit port with timer
// clock and analog pins, an 8-bit port with pull-ups and change detect.
// Assumes pins are asynchronous to sys_clk and an external pad resolves
// out/oe into the wire level; no wait state on any APB access.
// Function
// - Port A direction one means input, zero drives
// - Port A has six pins, own bits
// - Data read gives pins, write sets latch
// - Writes are read-modify-write into the latch
// - A bit4 is timer clock, open drain
// - After reset analog pins read zero
// - Analog field selects per-pin mode, resets 000
// - Unimplemented register bits read as zero
// - Port B has eight pins, same direction
// - Option bit7 low enables all pull-ups
// - Pull-up off on any output pin
// - Pull-ups disabled after reset
// - Only upper four input pins compared
// - OR of mismatches sets change flag
// - Change flag can wake from sleep
// - Port B access refreshes compare value
// - Persisting mismatch keeps setting the flag
// - B bit0 external irq, Schmitt when enabled
// - Enabled peripheral takes pin from GPIO
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dgp_port
  import dgp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [5:0]  paIn,
  output dgp_pa_drv_s      paDrv,
  output logic [5:0]       analogSel,
  output logic             timerClkIn,
  input  wire logic [7:0]  pbIn,
  output dgp_pb_drv_s      pbDrv,
  output logic [7:0]       pbPullupEn,
  output logic             extIrqIn,
  output logic             extIrqSchmitt,
  output logic             portChangeWake
);

  typedef struct packed {
    logic [5:0]  latchA;
    logic [5:0]  dirA;
    logic [2:0]  anCfg;
    logic [7:0]  latchB;
    logic [7:0]  dirB;
    logic [7:0]  option;
    logic        flag;
    logic        wakeEn;
    logic [1:0]  periph;
    logic [3:0]  oldB;
    logic [5:0]  syncA1;
    logic [5:0]  syncA2;
    logic [7:0]  syncB1;
    logic [7:0]  syncB2;
    logic [31:0] rdata;
  } dgp_state_s;

  dgp_state_s st_q;
  dgp_state_s st_d;

  logic [9:0] idx;
  logic       mapped;
  logic       setup;
  logic       access;
  logic       wrAcc;
  logic [5:0] anMask;
  logic [5:0] pinA;
  logic [7:0] pinB;
  logic       accB;
  logic       mismatch;
  logic [5:0] gpioA;
  logic [7:0] gpioB;

  assign idx    = paddr[11:2];
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wrAcc  = access && pwrite && mapped && pstrb[0];
  assign accB   = access && mapped && (idx == IDX_PB_DATA);

  always_comb begin
    case (idx)
      IDX_PA_DATA, IDX_PA_DIR, IDX_AN_CFG, IDX_PB_DATA,
      IDX_PB_DIR, IDX_OPTION, IDX_INT_CTL, IDX_PERIPH: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign anMask = dgp_analog_mask(st_q.anCfg);
  // Analog pins read as zero on the digital side
  assign pinA   = st_q.syncA2 & ~anMask;
  assign pinB   = st_q.syncB2;

  // Only input pins of the upper nibble take part
  assign mismatch = |((st_q.syncB2[7:4] ^ st_q.oldB) & st_q.dirB[7:4]);

  // An enabled peripheral forces its pin to input
  always_comb begin
    gpioA = st_q.dirA;
    gpioB = st_q.dirB;
    if (st_q.periph[POS_PER_TMR]) begin
      gpioA[POS_TMR_PIN] = 1'b1;
    end
    if (st_q.periph[POS_PER_EXT]) begin
      gpioB[POS_EXT_IRQ_PIN] = 1'b1;
    end
  end

  always_comb begin
    st_d        = st_q;
    st_d.syncA1 = paIn;
    st_d.syncA2 = st_q.syncA1;
    st_d.syncB1 = pbIn;
    st_d.syncB2 = st_q.syncB1;
    // Read data is captured in the setup cycle so prdata is a flop
    if (setup) begin
      st_d.rdata = 32'h0000_0000;
      case (idx)
        IDX_PA_DATA: st_d.rdata[5:0] = pinA;
        IDX_PA_DIR:  st_d.rdata[5:0] = st_q.dirA;
        IDX_AN_CFG:  st_d.rdata[2:0] = st_q.anCfg;
        IDX_PB_DATA: st_d.rdata[7:0] = pinB;
        IDX_PB_DIR:  st_d.rdata[7:0] = st_q.dirB;
        IDX_OPTION:  st_d.rdata[7:0] = st_q.option;
        IDX_INT_CTL: begin
          st_d.rdata[POS_CHANGE_FLAG] = st_q.flag;
          st_d.rdata[POS_WAKE_EN]     = st_q.wakeEn;
        end
        IDX_PERIPH:  st_d.rdata[1:0] = st_q.periph;
        default:     st_d.rdata = 32'h0000_0000;
      endcase
    end
    // Without the byte strobe, the latch still reloads from the pins
    if (access && pwrite && mapped && idx == IDX_PA_DATA) begin
      st_d.latchA = pstrb[0] ? pwdata[5:0] : pinA;
    end
    if (access && pwrite && mapped && idx == IDX_PB_DATA) begin
      st_d.latchB = pstrb[0] ? pwdata[7:0] : pinB;
    end
    if (wrAcc) begin
      case (idx)
        IDX_PA_DIR:  st_d.dirA   = pwdata[5:0];
        IDX_AN_CFG:  st_d.anCfg  = pwdata[2:0];
        IDX_PB_DIR:  st_d.dirB   = pwdata[7:0];
        IDX_OPTION:  st_d.option = pwdata[7:0];
        IDX_INT_CTL: begin
          st_d.flag   = st_q.flag & pwdata[POS_CHANGE_FLAG];
          st_d.wakeEn = pwdata[POS_WAKE_EN];
        end
        IDX_PERIPH:  st_d.periph = pwdata[1:0];
        default:     st_d.periph = st_q.periph;
      endcase
    end
    if (accB) begin
      st_d.oldB = st_q.syncB2[7:4];
    end
    // A mismatch wins over a software clear in the same cycle
    if (mismatch) begin
      st_d.flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_q        <= '0;
      st_q.latchA <= RST_PA_LAT;
      st_q.dirA   <= RST_PA_DIR;
      st_q.anCfg  <= RST_AN_CFG;
      st_q.latchB <= RST_PB_LAT;
      st_q.dirB   <= RST_PB_DIR;
      st_q.option <= RST_OPTION;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready  = access;
  assign pslverr = access && !mapped;
  assign prdata  = st_q.rdata;

  genvar gi;
  generate
    for (gi = 0; gi < PA_W; gi++) begin : g_pa
      if (gi == POS_TMR_PIN) begin : g_od
        // Open drain: only a low latch pulls the pin, never driven high
        assign paDrv.out[gi] = 1'b0;
        assign paDrv.oe[gi]  = !gpioA[gi] && !st_q.latchA[gi];
      end else begin : g_pp
        assign paDrv.out[gi] = st_q.latchA[gi];
        assign paDrv.oe[gi]  = !gpioA[gi];
      end
    end
    for (gi = 0; gi < PB_W; gi++) begin : g_pb
      assign pbDrv.out[gi]   = st_q.latchB[gi];
      assign pbDrv.oe[gi]    = !gpioB[gi];
      assign pbPullupEn[gi]  = !st_q.option[POS_PULLUP_DIS_N] && st_q.dirB[gi];
    end
  endgenerate

  assign analogSel      = anMask;
  assign timerClkIn     = st_q.syncA2[POS_TMR_PIN];
  assign extIrqIn       = st_q.syncB2[POS_EXT_IRQ_PIN];
  assign extIrqSchmitt  = st_q.periph[POS_PER_EXT];
  assign portChangeWake = st_q.flag && st_q.wakeEn;

  a_pa_dir_write:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrAcc && idx == IDX_PA_DIR && !st_q.periph[POS_PER_TMR])
      |=> paDrv.oe[3:0] == ~$past(pwdata[3:0]))
    else $error("port A drive does not follow written direction");

  a_od_never_high:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    paDrv.oe[POS_TMR_PIN] |-> !paDrv.out[POS_TMR_PIN] && !st_q.latchA[POS_TMR_PIN])
    else $error("timer clock pin driven high");

  a_pa_read_pins:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (setup && !pwrite && idx == IDX_PA_DATA)
      |=> pready && prdata[5:0] == ($past(st_q.syncA2) & ~$past(anMask)))
    else $error("port A read does not return pin levels");

  a_upper_zero:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    pready |-> prdata[31:8] == 24'h000000)
    else $error("unimplemented bits not zero");

  a_analog_reset:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(nrst) |-> analogSel == 6'h2f && st_q.anCfg == 3'h0)
    else $error("analog pins not selected after reset");

  a_pullup_output:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (pbPullupEn & ~st_q.dirB) == 8'h00)
    else $error("pull-up on output pin");

  a_pullup_reset:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(nrst) |-> pbPullupEn == 8'h00 [*2])
    else $error("pull-ups active after reset");

  a_change_set:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    mismatch |=> st_q.flag)
    else $error("mismatch did not set change flag");

  a_no_spurious:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (!st_q.flag && !mismatch) |=> !st_q.flag)
    else $error("change flag set without mismatch");

  a_refresh_old:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    accB |=> st_q.oldB == $past(st_q.syncB2[7:4]))
    else $error("compare value not refreshed");

  a_pa_dir_store:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrAcc && idx == IDX_PA_DIR) |=> st_q.dirA == $past(pwdata[5:0]))
    else $error("port A direction not stored");

  a_pa_latch_store:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrAcc && idx == IDX_PA_DATA) |=> st_q.latchA == $past(pwdata[5:0]))
    else $error("port A latch not written");

  a_pa_rmw_reload:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (access && pwrite && !pstrb[0] && idx == IDX_PA_DATA)
      |=> st_q.latchA == $past(pinA))
    else $error("port A latch not reloaded from pins");

  a_pb_rmw_reload:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (access && pwrite && !pstrb[0] && idx == IDX_PB_DATA)
      |=> st_q.latchB == $past(pinB))
    else $error("port B latch not reloaded from pins");

  a_pb_latch_drive:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrAcc && idx == IDX_PB_DATA) |=> pbDrv.out == $past(pwdata[7:0]))
    else $error("port B drive does not follow latch write");

  a_pb_dir_write:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrAcc && idx == IDX_PB_DIR && !st_q.periph[POS_PER_EXT])
      |=> pbDrv.oe == ~$past(pwdata[7:0]))
    else $error("port B drive does not follow written direction");

  a_pb_read_pins:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (setup && !pwrite && idx == IDX_PB_DATA)
      |=> pready && prdata[7:0] == $past(st_q.syncB2))
    else $error("port B read does not return pin levels");

  a_an_cfg_store:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrAcc && idx == IDX_AN_CFG) |=> st_q.anCfg == $past(pwdata[2:0]))
    else $error("analog configuration not stored");

  a_digital_all:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q.anCfg > 3'h4) |-> analogSel == 6'h00)
    else $error("analog pin selected in all-digital setting");

  a_analog_read_zero:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (pready && !pwrite && idx == IDX_PA_DATA) |-> (prdata[5:0] & analogSel) == 6'h00)
    else $error("analog pin reads nonzero");

  a_pullup_write:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrAcc && idx == IDX_OPTION && !pwdata[POS_PULLUP_DIS_N])
      |=> pbPullupEn == st_q.dirB)
    else $error("pull-ups not enabled on input pins");

  a_pullup_off:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q.option[POS_PULLUP_DIS_N] |-> pbPullupEn == 8'h00)
    else $error("pull-up on while globally disabled");

  a_out_excluded:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (!st_q.flag && st_q.dirB[7:4] == 4'h0) |=> !st_q.flag)
    else $error("output pins set the change flag");

  a_flag_clear:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrAcc && idx == IDX_INT_CTL && !pwdata[POS_CHANGE_FLAG] && !mismatch)
      |=> !st_q.flag)
    else $error("change flag not cleared");

  a_wake_follow:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (mismatch && st_q.wakeEn && !wrAcc) |=> portChangeWake)
    else $error("port change does not raise wake");

  a_schmitt_sel:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrAcc && idx == IDX_PERIPH) |=> extIrqSchmitt == $past(pwdata[POS_PER_EXT]))
    else $error("Schmitt select does not follow peripheral enable");

  a_tmr_forced_in:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q.periph[POS_PER_TMR] |-> !paDrv.oe[POS_TMR_PIN])
    else $error("timer clock pin driven while peripheral owns it");

  a_ext_forced_in:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q.periph[POS_PER_EXT] |-> !pbDrv.oe[POS_EXT_IRQ_PIN])
    else $error("interrupt pin driven while peripheral owns it");

  a_tmr_sync:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(nrst, 2) |-> timerClkIn == $past(paIn[POS_TMR_PIN], 2))
    else $error("timer clock input not two flops behind pin");

  a_irq_sync:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(nrst, 2) |-> extIrqIn == $past(pbIn[POS_EXT_IRQ_PIN], 2))
    else $error("interrupt input not two flops behind pin");

  a_unmapped_zero:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (pready && !mapped) |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

endmodule : dgp_port

`default_nettype wire

//--- tb/dgp_pin_model.sv
// Pin-side model: resolves device drive, outside drivers and pull-ups.
// Assumes the bench drives extA and extB; a zero bit in extBEn leaves that port B pin open.
`timescale 1ns/1ps
`default_nettype none
module dgp_pin_model
  import dgp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire dgp_pa_drv_s paDrv,
  input  wire dgp_pb_drv_s pbDrv,
  input  wire logic [7:0]  pbPullupEn,
  input  wire logic [5:0]  extA,
  input  wire logic [7:0]  extB,
  input  wire logic [7:0]  extBEn,
  output logic [5:0]       paIn,
  output logic [7:0]       pbIn
);
  // An open port B pin without pull-up wanders every cycle so a stale level never passes a check
  logic flip = 1'b0;
  always @(posedge sys_clk) flip <= ~flip;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      paIn[i] = paDrv.oe[i] ? paDrv.out[i] : extA[i];
    end
    for (int i = 0; i < 8; i++) begin
      pbIn[i] = pbDrv.oe[i] ? pbDrv.out[i] : (extBEn[i] ? extB[i] : (pbPullupEn[i] | flip));
    end
  end
endmodule : dgp_pin_model
`default_nettype wire

//--- tb/dgp_port_tb_top.sv
// Bench for the dual port block: APB tasks, pin model, directed tests.
// Assumes the slave answers in the access phase and 2-edge pin sync.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dgp_port_tb_top
  import dgp_pkg::*;
;
  logic        sys_clk, pready, pslverr, timerClkIn, extIrqIn, extIrqSchmitt, portChangeWake, err;
  logic        nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf, strb = 4'hf;
  logic [5:0]  paIn, analogSel, extA = 6'h15;
  logic [7:0]  pbIn, pbPullupEn, extB = 8'h51, extBEn = 8'hfd;
  dgp_pa_drv_s paDrv;
  dgp_pb_drv_s pbDrv;
  int          num_errors = 0, compares = 0;
  logic [5:0]  amask [8] = '{6'h2f, 6'h0f, 6'h07, 6'h03, 6'h01, 6'h00, 6'h00, 6'h00};

  dgp_port DUT (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .paIn(paIn), .paDrv(paDrv), .analogSel(analogSel),
    .timerClkIn(timerClkIn), .pbIn(pbIn), .pbDrv(pbDrv), .pbPullupEn(pbPullupEn),
    .extIrqIn(extIrqIn), .extIrqSchmitt(extIrqSchmitt), .portChangeWake(portChangeWake));
  dgp_pin_model pins (.sys_clk(sys_clk), .paDrv(paDrv), .pbDrv(pbDrv), .pbPullupEn(pbPullupEn),
    .extA(extA), .extB(extB), .extBEn(extBEn), .paIn(paIn), .pbIn(pbIn));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic finish_test;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // One idle cycle before each setup keeps a driver from assigning twice per step
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    pstrb   <= strb;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      num_errors++;
      finish_test();
    end
  endtask : xfer

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rdChk(input logic [9:0] idx, input logic [31:0] e);
    xfer(1'b0, idx, 32'h0);
    `CHK(rd, e)
  endtask : rdChk

  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    settle();
    `CHK(analogSel, 6'h2f)
    `CHK(pbPullupEn, 8'h00)
    `CHK({paDrv.oe, pbDrv.oe}, 14'h0)
    rdChk(IDX_PA_DIR, 32'h3f);
    rdChk(IDX_AN_CFG, 32'h0);
    rdChk(IDX_PB_DIR, 32'hff);
    rdChk(IDX_OPTION, 32'hff);
    rdChk(IDX_PA_DATA, 32'h10);
    xfer(1'b0, 10'h3ff, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    $display("reset test done");
    for (int c = 0; c < 8; c++) begin
      wr(IDX_AN_CFG, c);
      settle();
      `CHK(analogSel, amask[c])
    end
    wr(IDX_PA_DIR, 32'hffffffff);
    rdChk(IDX_PA_DIR, 32'h3f);
    rdChk(IDX_PA_DATA, 32'h15);
    wr(IDX_PA_DATA, 32'h2a);
    wr(IDX_PA_DIR, 32'h0);
    settle();
    `CHK(paDrv, {6'h2a, 6'h3f})
    rdChk(IDX_PA_DATA, 32'h2a);
    wr(IDX_PERIPH, 32'h1);
    settle();
    `CHK({paDrv.oe, timerClkIn}, 7'h5f)
    wr(IDX_PERIPH, 32'h0);
    wr(IDX_PA_DIR, 32'h3f);
    strb = 4'h0;
    wr(IDX_PA_DATA, 32'h0);
    strb = 4'hf;
    wr(IDX_PA_DIR, 32'h0);
    settle();
    `CHK(paDrv, {6'h05, 6'h2f})
    $display("port a test done");
    wr(IDX_OPTION, 32'h7f);
    wr(IDX_PB_DIR, 32'h1f);
    wr(IDX_PERIPH, 32'h2);
    settle();
    `CHK({pbPullupEn, pbDrv.oe}, 16'h1fe0)
    `CHK({extIrqSchmitt, extIrqIn}, 2'b11)
    rdChk(IDX_PB_DATA, 32'h13);
    wr(IDX_INT_CTL, 32'h0);
    rdChk(IDX_INT_CTL, 32'h0);
    extB <= 8'hd9;
    settle();
    rdChk(IDX_INT_CTL, 32'h0);
    extB <= 8'hc9;
    settle();
    rdChk(IDX_INT_CTL, 32'h1);
    wr(IDX_INT_CTL, 32'h0);
    rdChk(IDX_INT_CTL, 32'h1);
    wr(IDX_INT_CTL, 32'h2);
    settle();
    `CHK(portChangeWake, 1'b1)
    rdChk(IDX_PB_DATA, 32'h0b);
    wr(IDX_INT_CTL, 32'h2);
    rdChk(IDX_INT_CTL, 32'h2);
    `CHK(portChangeWake, 1'b0)
    // The write refreshes the compare value on the same edge that the outputs move
    wr(IDX_PB_DATA, 32'he0);
    settle();
    `CHK(pbDrv, {8'he0, 8'he0})
    rdChk(IDX_INT_CTL, 32'h2);
    rdChk(IDX_PB_DATA, 32'heb);
    $display("port b test done");
    finish_test();
  end
endmodule : dgp_port_tb_top
`default_nettype wire
